// *** common/trpc_map.svh ***
/*
 * Constants for the transfer relay pulse controller: channel count,
 * delay steps, pulse width and reset values.
 * Assumes a 100 MHz system clock.
 */
`ifndef TRPC_MAP_SVH
`define TRPC_MAP_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define TRPC_NUM_CH          4
`define TRPC_DLY_W           5

// ----------------------------------------
// Delay setting
// ----------------------------------------
`define TRPC_DLY_MAX         5'h13
`define TRPC_DLY_RESET       5'h02
`define TRPC_CLK_MHZ         100
`define TRPC_STEP_MS         50
`define TRPC_STEP_CYC        (`TRPC_STEP_MS * 1000 * `TRPC_CLK_MHZ)

// ----------------------------------------
// Pulse width
// ----------------------------------------
`define TRPC_PULSE_US        1000
`define TRPC_PULSE_CYC       (`TRPC_PULSE_US * `TRPC_CLK_MHZ)

`endif

// *** common/trpc_pkg.sv ***
/*
 * Types for the transfer relay pulse controller.
 * Assumes nothing beyond the constants header.
 */
package trpc_pkg;

    // ----------------------------------------
    // Channel state, one bit flips per step except WAIT back to IDLE
    // ----------------------------------------
    typedef enum logic [1:0] {
        TRPC_IDLE  = 2'h0,
        TRPC_PULSE = 2'h1,
        TRPC_WAIT  = 2'h3
    } trpc_state_t;

endpackage : trpc_pkg

// *** design/trpc_channel.sv ***
/*
 * One relay channel: takes a command, issues one pulse on one line,
 * then holds off further commands for the programmed delay.
 * Assumes commands are held on cmd_valid_i until cmd_ready_o, synchronous to ref_clk_i.
 */
`timescale 1ns/1ps
`include "trpc_map.svh"

module trpc_channel #(
    parameter int unsigned PULSE_CYC = `TRPC_PULSE_CYC,
    parameter int unsigned STEP_CYC  = `TRPC_STEP_CYC
) (
    // Clock and reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   resetn_i,
    // Command
    input  wire logic                   cmd_valid_i,
    input  wire logic                   cmd_activate_i,
    output wire logic                   cmd_ready_o,
    // Delay setting
    input  wire logic [`TRPC_DLY_W-1:0] delay_i,
    // Pulse lines
    output logic                        set_activate_o,
    output logic                        set_release_o,
    output wire logic                   busy_o
);

    trpc_pkg::trpc_state_t state_r;
    logic [31:0]                 cnt_r;
    logic [`TRPC_DLY_W-1:0]      steps_r;
    logic                        dir_r;

    wire cnt_done = (cnt_r == 32'h0000_0001);
    wire step_end = (steps_r == {`TRPC_DLY_W{1'b0}});

    assign cmd_ready_o = (state_r == trpc_pkg::TRPC_IDLE);
    assign busy_o      = ~cmd_ready_o;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r        <= trpc_pkg::TRPC_IDLE;
            cnt_r          <= 32'h0000_0000;
            steps_r        <= {`TRPC_DLY_W{1'b0}};
            dir_r          <= 1'b0;
            set_activate_o <= 1'b0;
            set_release_o  <= 1'b0;
        end else begin
            case (state_r)
                trpc_pkg::TRPC_IDLE: begin
                    if (cmd_valid_i) begin
                        set_activate_o <= cmd_activate_i;
                        set_release_o  <= ~cmd_activate_i;
                        dir_r          <= cmd_activate_i;
                        cnt_r          <= PULSE_CYC;
                        steps_r        <= delay_i;
                        state_r        <= trpc_pkg::TRPC_PULSE;
                    end
                end
                trpc_pkg::TRPC_PULSE: begin
                    if (cnt_done) begin
                        set_activate_o <= 1'b0;
                        set_release_o  <= 1'b0;
                        cnt_r          <= STEP_CYC;
                        state_r        <= step_end ? trpc_pkg::TRPC_IDLE
                                                   : trpc_pkg::TRPC_WAIT;
                    end else begin
                        cnt_r <= cnt_r - 32'h0000_0001;
                    end
                end
                trpc_pkg::TRPC_WAIT: begin
                    if (cnt_done) begin
                        cnt_r   <= STEP_CYC;
                        steps_r <= steps_r - {{(`TRPC_DLY_W-1){1'b0}}, 1'b1};
                        if (steps_r == {{(`TRPC_DLY_W-1){1'b0}}, 1'b1}) begin
                            state_r <= trpc_pkg::TRPC_IDLE;
                        end
                    end else begin
                        cnt_r <= cnt_r - 32'h0000_0001;
                    end
                end
                default: begin
                    state_r <= trpc_pkg::TRPC_IDLE;
                end
            endcase
        end
    end

endmodule : trpc_channel

// *** design/trpc_top.sv ***
/*
 * Transfer relay pulse controller: four latching transfer relays,
 * each with activate and release pulse lines, per-channel delay,
 * position readback, power-good and interlock indication.
 * Assumes all inputs synchronous to ref_clk_i; relays latch by themselves.
 * Assumes the host holds a command until cmd_ready_o shows it was taken.
 * Assumes unused relay connectors have their safety contacts bridged.
 * Position and power-good outputs are one-cycle registered copies of their inputs.
 * Neither reset ever drives a pulse line, so relays keep their position.
 * Delay writes above the top step are dropped and flagged.
 * Pulse width and step length are parameters sized for the system clock.
 * The aux power-good output follows its own supply input only.
 */
// How it works
// - Relays switched by short pulses only
// - Two pulse lines per relay channel
// - Four channels, each independent
// - Command resets leave relays and outputs
// - Wait programmed delay between commands
// - Each channel has its own delay
// - One delay unit is 50 ms
// - Delay 0 to 19, others rejected
// - Delay resets to 2, 100 ms
// - Status contact sampled, position reported
// - Power-good indicator per relay connector
// - Power-good indicator for aux connector
// - Closed interlock: LED off, status 1
// - Broken chain: red LED, status 0
`timescale 1ns/1ps
`include "trpc_map.svh"

module trpc_top #(
    parameter int unsigned PULSE_CYC = `TRPC_PULSE_CYC,
    parameter int unsigned STEP_CYC  = `TRPC_STEP_CYC
) (
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    resetn_i,
    // Commands per channel
    input  wire logic [`TRPC_NUM_CH-1:0] cmd_valid_i,
    input  wire logic [`TRPC_NUM_CH-1:0] cmd_activate_i,
    output wire logic [`TRPC_NUM_CH-1:0] cmd_ready_o,
    // Delay configuration
    input  wire logic                    dly_wr_i,
    input  wire logic [1:0]              dly_ch_i,
    input  wire logic [`TRPC_DLY_W-1:0]  dly_val_i,
    input  wire logic                    cfg_reset_i,
    output logic                         dly_reject_o,
    output logic [4*`TRPC_DLY_W-1:0]     dly_value_o,
    // Relay lines
    output wire logic [`TRPC_NUM_CH-1:0] set_activate_o,
    output wire logic [`TRPC_NUM_CH-1:0] set_release_o,
    output wire logic [`TRPC_NUM_CH-1:0] busy_o,
    input  wire logic [`TRPC_NUM_CH-1:0] relay_status_i,
    output logic [`TRPC_NUM_CH-1:0]      relay_position_o,
    // Power and interlock
    input  wire logic [`TRPC_NUM_CH-1:0] connector_supply_ok_i,
    input  wire logic                    aux_supply_ok_i,
    input  wire logic                    ext_interlock_closed_i,
    input  wire logic [`TRPC_NUM_CH-1:0] safety_contact_closed_i,
    output logic [`TRPC_NUM_CH-1:0]      connector_power_good_o,
    output logic                         aux_port_power_good_o,
    output logic                         interlock_led_o,
    output logic                         interlock_status_o
);

    logic [`TRPC_DLY_W-1:0] delay_r [`TRPC_NUM_CH];

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    // range check
    function automatic logic dly_in_range(input logic [`TRPC_DLY_W-1:0] val);
        return (val <= `TRPC_DLY_MAX);
    endfunction : dly_in_range

    // Channel select for a delay write
    function automatic logic ch_hit(input logic [1:0] sel, input logic [1:0] idx);
        return (sel == idx);
    endfunction : ch_hit

    // ----------------------------------------
    // Named decodes
    // ----------------------------------------
    wire                    dly_ok       = dly_in_range(dly_val_i);
    wire                    reject_nxt   = dly_wr_i & ~dly_ok;
    wire                    chain_closed = ext_interlock_closed_i & (&safety_contact_closed_i);
    wire                    led_nxt      = ~chain_closed;
    wire                    ilk_nxt      = chain_closed;
    wire [`TRPC_NUM_CH-1:0] position_nxt = relay_status_i;
    wire [`TRPC_NUM_CH-1:0] conn_pg_nxt  = connector_supply_ok_i;
    wire                    aux_pg_nxt   = aux_supply_ok_i;

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `TRPC_NUM_CH; g = g + 1) begin : g_ch
            trpc_channel #(
                .PULSE_CYC (PULSE_CYC),
                .STEP_CYC  (STEP_CYC)
            ) u_ch (
                .ref_clk_i      (ref_clk_i),
                .resetn_i       (resetn_i),
                .cmd_valid_i    (cmd_valid_i[g]),
                .cmd_activate_i (cmd_activate_i[g]),
                .cmd_ready_o    (cmd_ready_o[g]),
                .delay_i        (delay_r[g]),
                .set_activate_o (set_activate_o[g]),
                .set_release_o  (set_release_o[g]),
                .busy_o         (busy_o[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Delay storage
    // ----------------------------------------
    genvar d;
    generate
        for (d = 0; d < `TRPC_NUM_CH; d = d + 1) begin : g_dly
            always_ff @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    delay_r[d] <= `TRPC_DLY_RESET;
                end else if (cfg_reset_i) begin
                    delay_r[d] <= `TRPC_DLY_RESET;
                end else if (dly_wr_i && dly_ok && ch_hit(dly_ch_i, 2'(d))) begin
                    delay_r[d] <= dly_val_i;
                end
            end

            assign dly_value_o[d*`TRPC_DLY_W +: `TRPC_DLY_W] = delay_r[d];
        end
    endgenerate

    // ----------------------------------------
    // Delay rejection
    // ----------------------------------------
    // reject pulse
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dly_reject_o <= 1'b0;
        end else begin
            dly_reject_o <= reject_nxt;
        end
    end

    // ----------------------------------------
    // Position readback
    // ----------------------------------------
    // cfg reset touches only delays
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            relay_position_o <= 4'h0;
        end else begin
            relay_position_o <= position_nxt;
        end
    end

    // ----------------------------------------
    // Connector power good
    // ----------------------------------------
    // connector power good
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            connector_power_good_o <= 4'h0;
        end else begin
            connector_power_good_o <= conn_pg_nxt;
        end
    end

    // ----------------------------------------
    // Aux power good
    // ----------------------------------------
    // aux power good
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aux_port_power_good_o <= 1'b0;
        end else begin
            aux_port_power_good_o <= aux_pg_nxt;
        end
    end

    // ----------------------------------------
    // Interlock indicator
    // ----------------------------------------
    // led off when closed
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            interlock_led_o <= 1'b1;
        end else begin
            interlock_led_o <= led_nxt;
        end
    end

    // ----------------------------------------
    // Interlock status
    // ----------------------------------------
    // interlock status
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            interlock_status_o <= 1'b0;
        end else begin
            interlock_status_o <= ilk_nxt;
        end
    end

endmodule : trpc_top

// *** test/trpc_properties.sv ***
/* Port checker for trpc_top.
   Bound to every trpc_top instance, pulse width taken from that instance. */
`timescale 1ns/1ps
module trpc_properties #(parameter int unsigned PULSE_CYC = 4) (
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic [3:0]  cmd_valid_i,
    input wire logic [3:0]  cmd_activate_i,
    input wire logic [3:0]  cmd_ready_o,
    input wire logic        dly_wr_i,
    input wire logic [1:0]  dly_ch_i,
    input wire logic [4:0]  dly_val_i,
    input wire logic        cfg_reset_i,
    input wire logic        dly_reject_o,
    input wire logic [19:0] dly_value_o,
    input wire logic [3:0]  set_activate_o,
    input wire logic [3:0]  set_release_o,
    input wire logic [3:0]  relay_status_i,
    input wire logic [3:0]  relay_position_o,
    input wire logic [3:0]  connector_supply_ok_i,
    input wire logic        aux_supply_ok_i,
    input wire logic        ext_interlock_closed_i,
    input wire logic [3:0]  safety_contact_closed_i,
    input wire logic [3:0]  connector_power_good_o,
    input wire logic        aux_port_power_good_o,
    input wire logic        interlock_led_o,
    input wire logic        interlock_status_o
);
    wire logic [3:0] acc_a = cmd_valid_i & cmd_ready_o & cmd_activate_i;
    wire logic [3:0] acc_r = cmd_valid_i & cmd_ready_o & ~cmd_activate_i;
    wire logic       line0 = set_activate_o[0] | set_release_o[0];
    logic [31:0]     pw_r;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) pw_r <= '0;
        else pw_r <= line0 ? pw_r + 1 : '0;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_excl; (set_activate_o & set_release_o) == 4'h0; endproperty
    a_excl: assert property (p_excl) else $error("both pulse lines high");
    property p_pw; pw_r <= PULSE_CYC && (line0 || pw_r == 0 || pw_r == PULSE_CYC); endproperty
    a_pw: assert property (p_pw) else $error("pulse width wrong");
    property p_issue; |(acc_a | acc_r) |=> (set_activate_o & $past(acc_a)) == $past(acc_a)
        && (set_release_o & $past(acc_r)) == $past(acc_r); endproperty
    a_issue: assert property (p_issue) else $error("pulse on wrong line");
    property p_hold; cmd_valid_i[0] && cmd_ready_o[0] |=> !cmd_ready_o[0] [*4]; endproperty
    a_hold: assert property (p_hold) else $error("ready back too soon");
    property p_refuse; cmd_valid_i[0] && !cmd_ready_o[0] |=> !$rose(line0); endproperty
    a_refuse: assert property (p_refuse) else $error("busy command issued");
    property p_rej; dly_wr_i && !cfg_reset_i && dly_val_i > 5'h13
        |=> dly_reject_o && $stable(dly_value_o); endproperty
    a_rej: assert property (p_rej) else $error("bad delay not rejected");
    property p_wr; dly_wr_i && !cfg_reset_i && dly_val_i <= 5'h13
        |=> !dly_reject_o && dly_value_o[$past(dly_ch_i)*5 +: 5] == $past(dly_val_i); endproperty
    a_wr: assert property (p_wr) else $error("delay not stored");
    property p_cfg; cfg_reset_i |=> dly_value_o == {4{5'h02}}; endproperty
    a_cfg: assert property (p_cfg) else $error("delay default wrong");
    property p_stat; $past(resetn_i) |-> relay_position_o == $past(relay_status_i)
        && connector_power_good_o == $past(connector_supply_ok_i)
        && aux_port_power_good_o == $past(aux_supply_ok_i); endproperty
    a_stat: assert property (p_stat) else $error("status copy wrong");
    property p_ilk; $past(resetn_i) |-> interlock_led_o != interlock_status_o
        && interlock_status_o == $past(ext_interlock_closed_i && &safety_contact_closed_i);
    endproperty
    a_ilk: assert property (p_ilk) else $error("interlock wrong");
endmodule : trpc_properties
bind trpc_top trpc_properties #(.PULSE_CYC(PULSE_CYC)) u_props (.*);

// *** test/trpc_relay_model.sv ***
/* Four latching transfer relays with position and safety contacts.
   Driven by the controller pulse lines, same clock. */
`timescale 1ns/1ps
module trpc_relay_model (
    input  wire logic       ref_clk_i,
    input  wire logic [3:0] set_activate_i,
    input  wire logic [3:0] set_release_i,
    output logic      [3:0] status_o,
    output logic      [3:0] safety_o
);
    int move_cnt [4] = '{default: 0};
    initial status_o = 4'h0;
    initial safety_o = 4'hF;
    always @(posedge ref_clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (set_activate_i[i] | set_release_i[i]) begin
                status_o[i] <= set_activate_i[i];
                move_cnt[i] <= 3;
            end else if (move_cnt[i] > 0) move_cnt[i] <= move_cnt[i] - 1;
            safety_o[i] <= !(set_activate_i[i] | set_release_i[i]) && move_cnt[i] <= 1;
        end
    end
endmodule : trpc_relay_model

// *** test/tb.sv ***
/* Self-checking bench for trpc_top with relay model.
   Runs alone; short pulse and step counts. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
    localparam int PC = 4, SC = 10;
    logic ref_clk_i = 0, resetn_i = 0, dly_wr_i = 0, cfg_reset_i = 0, dly_reject_o;
    logic aux_supply_ok_i = 1, ext_interlock_closed_i = 1, aux_port_power_good_o;
    logic interlock_led_o, interlock_status_o;
    logic [3:0] cmd_valid_i = 0, cmd_activate_i = 0, connector_supply_ok_i = 4'hF;
    logic [3:0] cmd_ready_o, set_activate_o, set_release_o, busy_o, relay_status_i;
    logic [3:0] relay_position_o, safety_contact_closed_i, connector_power_good_o, keep;
    logic [1:0] dly_ch_i = 0;
    logic [4:0] dly_val_i = 0;
    logic [19:0] dly_value_o;
    logic [31:0] seed = 57647;
    int n_mismatch = 0, cmp_count = 0, n, dly[4] = '{2, 2, 2, 2};
    trpc_top #(.PULSE_CYC(PC), .STEP_CYC(SC)) DUT (.*);
    trpc_relay_model u_relay (.ref_clk_i, .set_activate_i(set_activate_o),
        .set_release_i(set_release_o), .status_o(relay_status_i),
        .safety_o(safety_contact_closed_i));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic wr_dly(int ch, logic [4:0] v);
        dly_wr_i = 1;
        dly_ch_i = 2'(ch);
        dly_val_i = v;
        @(negedge ref_clk_i);
        if (v <= 19) dly[ch] = v;
        `CHK("reject", v > 19, dly_reject_o)
        `CHK("delay", 5'(dly[ch]), dly_value_o[ch*5 +: 5])
    endtask : wr_dly
    task automatic run_cmd(int ch, logic dir, int reps);
        int hi, wl, bz, lo;
        logic [3:0] oth;
        cmd_activate_i[ch] = dir;
        cmd_valid_i[ch] = 1;
        for (n = 0; n < 1000 && !cmd_ready_o[ch]; n++) @(negedge ref_clk_i);
        if (n == 1000) begin n_mismatch++; wrap_up(); end
        for (int r = 0; r < reps; r++) begin
            @(negedge ref_clk_i);
            if (r == reps - 1) cmd_valid_i[ch] = 0;
            hi = 0;
            wl = 0;
            bz = 0;
            lo = 0;
            oth = 4'h0;
            for (n = 0; n < 1000 && !cmd_ready_o[ch]; n++) begin
                hi += dir ? set_activate_o[ch] : set_release_o[ch];
                wl += dir ? set_release_o[ch] : set_activate_o[ch];
                bz += busy_o[ch];
                lo += !interlock_status_o;
                oth |= (set_activate_o | set_release_o) & ~(4'h1 << ch);
                @(negedge ref_clk_i);
            end
            if (n == 1000) begin n_mismatch++; wrap_up(); end
            `CHK("busy", PC + dly[ch] * SC, n)
            `CHK("pulse", PC, hi)
            `CHK("wrong", 0, wl)
            `CHK("busy_o", PC + dly[ch] * SC, bz)
            `CHK("ilk_move", 1'b1, lo > 0)
            `CHK("other", 4'h0, oth)
            `CHK("pos", dir, relay_position_o[ch])
        end
    endtask : run_cmd
    initial begin
        repeat (8) @(negedge ref_clk_i);
        resetn_i = 1;
        `CHK("dly_rst", {4{5'h02}}, dly_value_o)
        for (int i = 0; i < 12; i++) wr_dly(i % 4, 5'(rnd() % 24));
        dly_wr_i = 0;
        cfg_reset_i = 1;
        @(negedge ref_clk_i);
        cfg_reset_i = 0;
        dly = '{2, 2, 2, 2};
        `CHK("cfg", {4{5'h02}}, dly_value_o)
        `CHK("cfg_line", 4'h0, set_activate_o | set_release_o)
        for (int i = 0; i < 8; i++) begin
            wr_dly(i % 4, i < 2 ? 5'(19 * i) : 5'(rnd() % 20));
            dly_wr_i = 0;
            run_cmd(i % 4, 1'(rnd()), 1 + i % 2);
        end
        keep = relay_position_o;
        resetn_i = 0;
        repeat (3) @(negedge ref_clk_i);
        resetn_i = 1;
        repeat (8) @(negedge ref_clk_i);
        `CHK("keep", keep, relay_position_o)
        `CHK("dly_rst2", {4{5'h02}}, dly_value_o)
        for (int i = 0; i < 8; i++) begin
            {aux_supply_ok_i, ext_interlock_closed_i, connector_supply_ok_i} = 6'(rnd());
            @(negedge ref_clk_i);
            `CHK("pg", connector_supply_ok_i, connector_power_good_o)
            `CHK("aux", aux_supply_ok_i, aux_port_power_good_o)
            `CHK("ilk", ext_interlock_closed_i & (&safety_contact_closed_i), interlock_status_o)
            `CHK("led", !(ext_interlock_closed_i & (&safety_contact_closed_i)), interlock_led_o)
        end
        wrap_up();
    end
endmodule : tb
